//--- hdl/wwdc_top.sv
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - Clock-select code 000 picks the low-frequency internal oscillator; the blank default is code 111.
// - Clock-select code 001 picks the mid-frequency oscillator output as reference.
// - Code 111 hands source choice to software; reserved codes select no source.
// - The window field loads the window at reset; 000-101 are fixed, 110/111 are open and soft.
// - Mode 11 runs the watchdog awake and asleep, ignoring the software enable.
// - Mode 10 runs it while awake and suspends it in sleep, ignoring the software enable.
// - Mode 01 lets the software enable bit turn the watchdog on or off.
// - Mode 00 keeps the watchdog off whatever the software enable says.
// - The period field sets a divide by two to the n+5 at reset; codes above 10010 divide by 32.
// - Bit 7 of the configuration word always reads as one.
// - A blank configuration memory reads as all ones in every field.
module wwdc_top (
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	input  wire logic [13:0] CFG_WORD,
	input  wire logic        CFG_BLANK,
	input  wire logic        LF_TICK,
	input  wire logic        MF_TICK,
	input  wire logic        SLEEP,
	input  wire logic [3:0]  ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [15:0] RDATA,
	output logic             DEVICE_RESET,
	output logic             IRQ
);
	logic [13:0] cfg;
	logic        cfg_loaded;
	logic [15:0] control;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic        clear_req;
	logic [13:0] next_cfg;
	logic        next_cfg_loaded;
	logic [15:0] next_control;
	logic [1:0]  next_status;
	logic [1:0]  next_mask;
	logic        next_clear_req;
	logic [15:0] next_rdata;
	logic        next_device_reset;
	logic        next_irq;
	logic [2:0]  cfg_source;
	logic [2:0]  cfg_window;
	logic [1:0]  cfg_mode;
	logic [4:0]  cfg_period;
	logic        window_soft;
	logic [2:0]  window_now;
	logic        wd_enable;
	logic        ref_tick;
	logic [22:0] count;
	logic        timeout;
	logic        violation;
	logic [1:0]  events;
	logic        wr_control;
	logic        wr_clear;
	logic        wr_status;
	logic        wr_mask;

	assign cfg_source  = cfg[wwdc_pkg::CCS_MSB:wwdc_pkg::CCS_LSB];
	assign cfg_window  = cfg[wwdc_pkg::CWS_MSB:wwdc_pkg::CWS_LSB];
	assign cfg_mode    = cfg[wwdc_pkg::MODE_MSB:wwdc_pkg::MODE_LSB];
	assign cfg_period  = cfg[wwdc_pkg::CPS_MSB:wwdc_pkg::CPS_LSB];
	assign window_soft = (cfg_window >= wwdc_pkg::CWS_SW_FIRST);
	assign window_now  = window_soft ? control[wwdc_pkg::CTL_WS_MSB:wwdc_pkg::CTL_WS_LSB]
	                                 : cfg_window;

	always_comb begin
		case (cfg_mode)
			wwdc_pkg::MODE_ALWAYS:   wd_enable = cfg_loaded;
			wwdc_pkg::MODE_AWAKE:    wd_enable = cfg_loaded && !SLEEP;
			wwdc_pkg::MODE_SOFTWARE: wd_enable = cfg_loaded && control[wwdc_pkg::CTL_SWEN_BIT];
			wwdc_pkg::MODE_OFF:      wd_enable = 1'b0;
			default:                 wd_enable = 1'b0;
		endcase
	end

	wwdc_refsel u_refsel (
		.clk        (REF_CLK),
		.resetn     (RESETN),
		.cfg_source (cfg_source),
		.sw_source  (control[wwdc_pkg::CTL_CS_MSB:wwdc_pkg::CTL_CS_LSB]),
		.lf_tick    (LF_TICK),
		.mf_tick    (MF_TICK),
		.ref_tick   (ref_tick)
	);

	wwdc_counter u_counter (
		.clk         (REF_CLK),
		.resetn      (RESETN),
		.enable      (wd_enable),
		.tick        (ref_tick),
		.clear       (clear_req),
		.period_code (cfg_period),
		.window_code (window_now),
		.count       (count),
		.timeout     (timeout),
		.violation   (violation)
	);

	assign events = {violation, timeout};

	assign wr_control = WR && (ADDR == wwdc_pkg::REG_CONTROL);
	assign wr_clear   = WR && (ADDR == wwdc_pkg::REG_CLEAR);
	assign wr_status  = WR && (ADDR == wwdc_pkg::REG_STATUS);
	assign wr_mask    = WR && (ADDR == wwdc_pkg::REG_MASK);

	// configuration is caught once, on the first cycle after reset release
	always_comb begin
		next_cfg        = cfg;
		next_cfg_loaded = 1'b1;
		if (!cfg_loaded) begin
			if (CFG_BLANK)
				next_cfg = wwdc_pkg::CFG_BLANK_WORD;
			else
				next_cfg = CFG_WORD;
			next_cfg[wwdc_pkg::UNIMPL_BIT] = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			cfg        <= wwdc_pkg::CFG_BLANK_WORD;
			cfg_loaded <= 1'b0;
		end else begin
			cfg        <= next_cfg;
			cfg_loaded <= next_cfg_loaded;
		end
	end

	// software control: enable, clock choice and, when left open, the window
	always_comb begin
		next_control = control;
		if (wr_control) begin
			next_control[wwdc_pkg::CTL_SWEN_BIT] = WDATA[wwdc_pkg::CTL_SWEN_BIT];
			next_control[wwdc_pkg::CTL_CS_MSB:wwdc_pkg::CTL_CS_LSB] =
				WDATA[wwdc_pkg::CTL_CS_MSB:wwdc_pkg::CTL_CS_LSB];
			// fixed window codes keep the field locked against software
			if (window_soft)
				next_control[wwdc_pkg::CTL_WS_MSB:wwdc_pkg::CTL_WS_LSB] =
					WDATA[wwdc_pkg::CTL_WS_MSB:wwdc_pkg::CTL_WS_LSB];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			control <= wwdc_pkg::CONTROL_RESET;
		else
			control <= next_control;
	end

	// only the key value arms a clear; anything else is dropped
	always_comb begin
		next_clear_req = 1'b0;
		if (wr_clear)
			next_clear_req = (WDATA == wwdc_pkg::CLEAR_KEY);
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			clear_req <= 1'b0;
		else
			clear_req <= next_clear_req;
	end

	// sticky event bits: a set in the same cycle as a write-one clear wins
	for (genvar b = 0; b < wwdc_pkg::ST_W; b++) begin : g_status
		assign next_status[b] = events[b] | (status[b] & !(wr_status && WDATA[b]));
	end

	always_comb begin
		next_mask = mask;
		if (wr_mask)
			next_mask = WDATA[wwdc_pkg::ST_W-1:0];
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			status <= 2'h0;
			mask   <= 2'h0;
		end else begin
			status <= next_status;
			mask   <= next_mask;
		end
	end

	// read data stand for the one cycle after the strobe and are zero otherwise
	always_comb begin
		next_rdata = 16'h0000;
		if (RD) begin
			case (ADDR)
				wwdc_pkg::REG_CONFIG:  next_rdata = {2'h0, cfg};
				wwdc_pkg::REG_CONTROL: next_rdata = control;
				wwdc_pkg::REG_STATUS:  next_rdata = {14'h0000, status};
				wwdc_pkg::REG_MASK:    next_rdata = {14'h0000, mask};
				wwdc_pkg::REG_COUNT:   next_rdata = count[22:7];
				default:               next_rdata = 16'h0000;
			endcase
		end
	end

	always_comb begin
		next_device_reset = timeout | violation;
		next_irq          = |(next_status & next_mask);
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			RDATA        <= 16'h0000;
			DEVICE_RESET <= 1'b0;
			IRQ          <= 1'b0;
		end else begin
			RDATA        <= next_rdata;
			DEVICE_RESET <= next_device_reset;
			IRQ          <= next_irq;
		end
	end
endmodule // wwdc_top

//--- hdl/wwdc_pkg.sv
package wwdc_pkg;
	// configuration word layout
	localparam int          CFG_W          = 14;
	localparam int          CCS_MSB        = 13;
	localparam int          CCS_LSB        = 11;
	localparam int          CWS_MSB        = 10;
	localparam int          CWS_LSB        = 8;
	localparam int          UNIMPL_BIT     = 7;
	localparam int          MODE_MSB       = 6;
	localparam int          MODE_LSB       = 5;
	localparam int          CPS_MSB        = 4;
	localparam int          CPS_LSB        = 0;
	localparam logic [13:0] CFG_BLANK_WORD = 14'h3FFF;

	// clock source codes
	localparam logic [2:0]  CCS_LFOSC      = 3'h0;
	localparam logic [2:0]  CCS_MFOSC      = 3'h1;
	localparam logic [2:0]  CCS_SOFTWARE   = 3'h7;

	// operating modes
	localparam logic [1:0]  MODE_OFF       = 2'h0;
	localparam logic [1:0]  MODE_SOFTWARE  = 2'h1;
	localparam logic [1:0]  MODE_AWAKE     = 2'h2;
	localparam logic [1:0]  MODE_ALWAYS    = 2'h3;

	// window codes: at or above this code the window is fully open
	localparam logic [2:0]  CWS_SW_FIRST   = 3'h6;
	localparam logic [2:0]  CWS_OPEN       = 3'h7;
	localparam logic [2:0]  CLOSED_EIGHTHS = 3'h7;

	// period codes
	localparam logic [4:0]  CPS_MAX_CODE   = 5'h12;
	localparam logic [4:0]  CPS_FALLBACK   = 5'h00;
	localparam int          CPS_BASE_EXP   = 5;
	localparam int          CNT_W          = 23;

	// register indices on the plain register port
	localparam logic [3:0]  REG_CONFIG     = 4'h0;
	localparam logic [3:0]  REG_CONTROL    = 4'h1;
	localparam logic [3:0]  REG_CLEAR      = 4'h2;
	localparam logic [3:0]  REG_STATUS     = 4'h3;
	localparam logic [3:0]  REG_MASK       = 4'h4;
	localparam logic [3:0]  REG_COUNT      = 4'h5;

	// control register fields
	localparam int          CTL_SWEN_BIT   = 0;
	localparam int          CTL_CS_MSB     = 2;
	localparam int          CTL_CS_LSB     = 1;
	localparam int          CTL_WS_MSB     = 6;
	localparam int          CTL_WS_LSB     = 4;
	localparam logic [15:0] CONTROL_RESET  = 16'h0070;
	localparam logic [1:0]  SWCS_LFOSC     = 2'h0;
	localparam logic [1:0]  SWCS_MFOSC     = 2'h1;

	// clear key and status bits
	localparam logic [15:0] CLEAR_KEY      = 16'h005A;
	localparam int          ST_TIMEOUT     = 0;
	localparam int          ST_VIOLATION   = 1;
	localparam int          ST_W           = 2;
endpackage

//--- hdl/wwdc_refsel.sv
`timescale 1ns/1ps
module wwdc_refsel (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [2:0] cfg_source,
	input  wire logic [1:0] sw_source,
	input  wire logic       lf_tick,
	input  wire logic       mf_tick,
	output logic            ref_tick
);
	logic next_ref_tick;

	always_comb begin
		next_ref_tick = 1'b0;
		case (cfg_source)
			wwdc_pkg::CCS_LFOSC:    next_ref_tick = lf_tick;
			wwdc_pkg::CCS_MFOSC:    next_ref_tick = mf_tick;
			wwdc_pkg::CCS_SOFTWARE: begin
				case (sw_source)
					wwdc_pkg::SWCS_LFOSC: next_ref_tick = lf_tick;
					wwdc_pkg::SWCS_MFOSC: next_ref_tick = mf_tick;
					default:              next_ref_tick = 1'b0;
				endcase
			end
			// reserved codes give no reference at all
			default:                next_ref_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			ref_tick <= 1'b0;
		else
			ref_tick <= next_ref_tick;
	end
endmodule // wwdc_refsel

//--- hdl/wwdc_counter.sv
`timescale 1ns/1ps
module wwdc_counter (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        tick,
	input  wire logic        clear,
	input  wire logic [4:0]  period_code,
	input  wire logic [2:0]  window_code,
	output logic [22:0]      count,
	output logic             timeout,
	output logic             violation
);
	logic [4:0]  exp_n;
	logic [2:0]  closed;
	logic [2:0]  eighth;
	logic [22:0] terminal;
	logic        win_closed;
	logic [22:0] next_count;
	logic        next_timeout;
	logic        next_violation;

	always_comb begin
		// out-of-table codes fall back to divide by 32
		exp_n      = (period_code > wwdc_pkg::CPS_MAX_CODE) ? wwdc_pkg::CPS_FALLBACK
		                                                    : period_code;
		terminal   = 23'((24'h000001 << (exp_n + 5'(wwdc_pkg::CPS_BASE_EXP))) - 24'h000001);
		closed     = (window_code >= wwdc_pkg::CWS_SW_FIRST) ? 3'h0
		                                                     : wwdc_pkg::CLOSED_EIGHTHS - window_code;
		eighth     = 3'(count >> (exp_n + 5'h02));
		win_closed = (eighth < closed);
		next_count     = count;
		next_timeout   = 1'b0;
		next_violation = 1'b0;
		if (clear) begin
			next_count     = 23'h000000;
			next_violation = enable && win_closed;
		end else if (enable && tick) begin
			if (count >= terminal) begin
				next_count   = 23'h000000;
				next_timeout = 1'b1;
			end else begin
				next_count = count + 23'h000001;
			end
		end else if (!enable) begin
			next_count = 23'h000000;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			count     <= 23'h000000;
			timeout   <= 1'b0;
			violation <= 1'b0;
		end else begin
			count     <= next_count;
			timeout   <= next_timeout;
			violation <= next_violation;
		end
	end
endmodule // wwdc_counter

//--- sim/wwdc_chk_sva.sv
`timescale 1ns/1ps
module wwdc_chk (
	input wire logic        REF_CLK,
	input wire logic        RESETN,
	input wire logic [13:0] CFG_WORD,
	input wire logic        CFG_BLANK,
	input wire logic        SLEEP,
	input wire logic [3:0]  ADDR,
	input wire logic [15:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [15:0] RDATA,
	input wire logic        DEVICE_RESET,
	input wire logic        IRQ
);
	logic        first;
	logic [13:0] word_q;
	// mirror of the word as it is loaded the edge after reset release
	always_ff @(posedge REF_CLK) begin
		first <= !RESETN;
		if (first && RESETN)
			word_q <= CFG_BLANK ? wwdc_pkg::CFG_BLANK_WORD : (CFG_WORD | 14'h0080);
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	sequence cfg_rd;
		RD && ADDR == wwdc_pkg::REG_CONFIG && !first;
	endsequence
	sequence mask_off;
		WR && ADDR == wwdc_pkg::REG_MASK && WDATA == 16'h0000 ##1 !(WR && ADDR == wwdc_pkg::REG_MASK)
		##1 !(WR && ADDR == wwdc_pkg::REG_MASK);
	endsequence
	a_cfg_echo: assert property (cfg_rd |=> RDATA == {2'h0, word_q})
		else $error("config readback differs from loaded word");
	a_pulse_single: assert property (DEVICE_RESET |=> !DEVICE_RESET)
		else $error("device reset longer than one cycle");
	a_off_quiet: assert property (!first && word_q[6:5] == wwdc_pkg::MODE_OFF |-> !DEVICE_RESET)
		else $error("device reset with watchdog off");
	a_sleep_quiet: assert property ((word_q[6:5] == wwdc_pkg::MODE_AWAKE && SLEEP)[*5] |-> !DEVICE_RESET)
		else $error("device reset while suspended in sleep");
	a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data outside read answer");
	a_unmapped_zero: assert property (RD && ADDR > wwdc_pkg::REG_COUNT |=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_mask_irq_off: assert property (mask_off |=> !IRQ)
		else $error("interrupt with empty mask");
	a_release_quiet: assert property ($rose(RESETN) |-> !DEVICE_RESET && !IRQ && RDATA == 16'h0000)
		else $error("outputs active after reset");
endmodule // wwdc_chk

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        ref_clk = 1'h0;
	logic        resetn = 1'h0;
	logic [13:0] cfg_word = 14'h0000;
	logic        cfg_blank = 1'h1, lf_tick = 1'h0, mf_tick = 1'h0, sleep = 1'h0;
	logic        wr = 1'h0, rd = 1'h0, device_reset, irq;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, v, w;
	logic [1:0]  modes [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
	int          errors = 0, checks = 0, pulses = 0, cycles = 0;
	always #25 ref_clk = ~ref_clk;
	wwdc_top dut_u (.REF_CLK(ref_clk), .RESETN(resetn), .CFG_WORD(cfg_word), .CFG_BLANK(cfg_blank),
		.LF_TICK(lf_tick), .MF_TICK(mf_tick), .SLEEP(sleep), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .DEVICE_RESET(device_reset), .IRQ(irq));
	task cyc(); @(posedge ref_clk); if (device_reset === 1'h1) pulses++; endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task reg_wr(input logic [3:0] a, input logic [15:0] d);
		addr <= a; wdata <= d; wr <= 1'h1; cyc(); wr <= 1'h0; cyc();
	endtask
	task reg_rd(input logic [3:0] a, output logic [15:0] d);
		addr <= a; rd <= 1'h1; cyc(); rd <= 1'h0; cyc(); d = rdata;
	endtask
	task tick(input int n, input logic l, input logic m);
		repeat (n) begin
			lf_tick <= l; mf_tick <= m; cyc(); lf_tick <= 1'h0; mf_tick <= 1'h0; cyc();
		end
	endtask
	task expect_pulses(input int e); repeat (4) cyc(); chk("timeouts", 16'(e), 16'(pulses)); pulses = 0; endtask
	task setup(input logic [13:0] c);
		resetn <= 1'h0; cfg_word <= c; cfg_blank <= 1'h0; repeat (2) cyc(); resetn <= 1'h1; repeat (3) cyc();
		pulses = 0;
	endtask
	function automatic logic [13:0] cfg(logic [2:0] s, logic [2:0] x, logic [1:0] m, logic [4:0] p);
		return {s, x, 1'h1, m, p};
	endfunction
	task conclude();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (6) cyc();
		resetn <= 1'h1; repeat (3) cyc();
		reg_rd(wwdc_pkg::REG_CONFIG, v); chk("config", 16'h3FFF, v);
		reg_rd(4'hF, v); chk("unmapped", 16'h0000, v);
		setup(14'h0000); reg_rd(wwdc_pkg::REG_CONFIG, v); chk("config", 16'h0080, v);
		for (int i = 0; i < 5; i++) begin
			sleep <= (i == 2 || i == 3);
			setup(cfg(3'h0, 3'h7, modes[i], 5'h00)); tick(32, 1'h1, 1'h0);
			expect_pulses(int'(i > 2));
		end
		sleep <= 1'h0;
		setup(cfg(3'h0, 3'h7, 2'h1, 5'h00)); reg_wr(wwdc_pkg::REG_CONTROL, 16'h0071);
		tick(32, 1'h1, 1'h0); expect_pulses(1);
		setup(cfg(3'h1, 3'h7, 2'h3, 5'h00)); tick(32, 1'h1, 1'h0); tick(32, 1'h0, 1'h1);
		expect_pulses(1);
		setup(cfg(3'h7, 3'h7, 2'h3, 5'h00)); reg_wr(wwdc_pkg::REG_CONTROL, 16'h0072);
		tick(32, 1'h0, 1'h1); expect_pulses(1);
		setup(cfg(3'h2, 3'h7, 2'h3, 5'h00)); tick(32, 1'h1, 1'h1); expect_pulses(0);
		setup(cfg(3'h0, 3'h7, 2'h3, 5'h01)); tick(63, 1'h1, 1'h0); expect_pulses(0);
		tick(1, 1'h1, 1'h0); expect_pulses(1);
		reg_rd(wwdc_pkg::REG_STATUS, v); chk("status", 16'h0001, v);
		reg_wr(wwdc_pkg::REG_MASK, 16'h0001); cyc(); chk("irq", 16'h0001, {15'h0000, irq});
		reg_rd(wwdc_pkg::REG_MASK, v); chk("mask", 16'h0001, v);
		reg_wr(wwdc_pkg::REG_STATUS, 16'h0003); cyc(); chk("irq", 16'h0000, {15'h0000, irq});
		reg_wr(wwdc_pkg::REG_MASK, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			setup(cfg(3'h0, 3'h7, 2'h3, i ? 5'h1E : 5'h13)); tick(32, 1'h1, 1'h0);
			expect_pulses(1);
		end
		// half of a 256-tick period is closed
		setup(cfg(3'h0, 3'h3, 2'h3, 5'h03)); reg_rd(wwdc_pkg::REG_CONTROL, v);
		reg_wr(wwdc_pkg::REG_CONTROL, 16'h0000); reg_rd(wwdc_pkg::REG_CONTROL, w);
		chk("window", 16'h0070, v & 16'h0070);
		chk("window", 16'h0070, w & 16'h0070);
		tick(10, 1'h1, 1'h0); reg_wr(wwdc_pkg::REG_CLEAR, 16'h0000); expect_pulses(0);
		reg_wr(wwdc_pkg::REG_CLEAR, wwdc_pkg::CLEAR_KEY); expect_pulses(1);
		reg_rd(wwdc_pkg::REG_STATUS, v); chk("status", 16'h0002, v);
		tick(200, 1'h1, 1'h0);
		reg_rd(wwdc_pkg::REG_COUNT, v); chk("count", 16'h0001, v);
		reg_wr(wwdc_pkg::REG_CLEAR, wwdc_pkg::CLEAR_KEY);
		tick(200, 1'h1, 1'h0); expect_pulses(0);
		setup(cfg(3'h0, 3'h7, 2'h3, 5'h03)); reg_wr(wwdc_pkg::REG_CLEAR, wwdc_pkg::CLEAR_KEY);
		expect_pulses(0);
		// an open word lets software close seven eighths of the period
		reg_wr(wwdc_pkg::REG_CONTROL, 16'h0000); reg_rd(wwdc_pkg::REG_CONTROL, v);
		chk("control", 16'h0000, v);
		tick(10, 1'h1, 1'h0); reg_wr(wwdc_pkg::REG_CLEAR, wwdc_pkg::CLEAR_KEY);
		expect_pulses(1);
		conclude();
	end
endmodule // tb_top
bind wwdc_top wwdc_chk chk_u (
	.REF_CLK      (REF_CLK),
	.RESETN       (RESETN),
	.CFG_WORD     (CFG_WORD),
	.CFG_BLANK    (CFG_BLANK),
	.SLEEP        (SLEEP),
	.ADDR         (ADDR),
	.WDATA        (WDATA),
	.WR           (WR),
	.RD           (RD),
	.RDATA        (RDATA),
	.DEVICE_RESET (DEVICE_RESET),
	.IRQ          (IRQ)
);
